/* src/dsso_cfg.svh */
/*
 * Constants of the drive status output block: register offsets, field
 * positions, reset values, limits, timing counts and selection codes.
 * Assumes inclusion by the block's top module and its bench; holds definitions only.
 */
`ifndef DSSO_CFG_SVH
`define DSSO_CFG_SVH
// Behaviour
// [R1] Link loss flag exists only while the serial port runs Modbus RTU.
// [R2] After a timeout the link loss flag holds until the next data arrives.
// [R3] Timeout when no data arrives within the 0.00 to 99.99 s limit.
// [R4] Run command present is high while an operation command is received.
// [R5] Run command present follows whichever command source is selected.
// [R6] Forward and reverse commands together stop the motor.
// [R7] Heat sink warning when temperature exceeds the 0 to 110 C level.
// [R8] Selection code 42 routes the heat sink warning to both outputs.
// [R9] Low current flag when output current is at or below the level.
// [R10] Low current mode 00 evaluates the flag during all operation.
// [R11] Low current mode 01 evaluates the flag only at constant speed.
// [R12] Selection code 43 routes the low current flag to both outputs.
// [R13] Drive ready flag is high whenever a command can be accepted.
// [R14] Commands act only while ready; the commander sends only then.
// [R15] Relay selection code 50 routes the drive ready flag.
// [R16] Forward running high while driving forward, low in reverse or stop.
// [R17] Relay selection code 51 routes the forward running flag.
// [R18] Commander uses mode 00 or more filtering with terminal speed source.
// [R19] Terminal and relay each take their own two-digit selection code.
// [R20] Each output follows the flag its code names, every clock cycle.

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define DSSO_OFF_CTRL 8'h00
`define DSSO_OFF_TMO 8'h04
`define DSSO_OFF_HEAT 8'h08
`define DSSO_OFF_LOCUR 8'h0c
`define DSSO_OFF_SEL 8'h10
`define DSSO_OFF_SWCMD 8'h14
`define DSSO_OFF_STAT 8'h18

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define DSSO_CTRL_RTU 0
`define DSSO_CTRL_SRC_LSB 1
`define DSSO_CTRL_LCM_LSB 3
`define DSSO_SEL_TERM_LSB 0
`define DSSO_SEL_RELAY_LSB 8
`define DSSO_SWCMD_FWD 0
`define DSSO_SWCMD_REV 1
`define DSSO_STAT_STATE_LSB 8

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define DSSO_CTRL_RST 5'h00
`define DSSO_TMO_RST 16'h0000
`define DSSO_TMO_MAX 16'h270f
`define DSSO_HEAT_RST 8'h5a
`define DSSO_HEAT_MAX 8'h6e
`define DSSO_LOCUR_RST 16'h0000
`define DSSO_SEL_RST 6'h00

// ------------------------------------------------------------
// Timing: one timeout step is 10 ms
// ------------------------------------------------------------
`define DSSO_CLK_KHZ 100000
`define DSSO_TICK_MS 10
`define DSSO_TICK_CYCLES (`DSSO_TICK_MS * `DSSO_CLK_KHZ)

// ------------------------------------------------------------
// Command sources, low current modes, selection codes
// ------------------------------------------------------------
`define DSSO_SRC_TERM 2'h0
`define DSSO_SRC_SERIAL 2'h1
`define DSSO_SRC_SW 2'h2
`define DSSO_LCM_RUN 2'h0
`define DSSO_LCM_CONST 2'h1
`define DSSO_TSEL_LINK 6'h20
`define DSSO_RSEL_LINK 6'h34
`define DSSO_TSEL_RUNCMD 6'h2c
`define DSSO_RSEL_RUNCMD 6'h29
`define DSSO_SEL_HEAT 6'h2a
`define DSSO_SEL_LOCUR 6'h2b
`define DSSO_SEL_READY 6'h32
`define DSSO_SEL_FWDRUN 6'h33
`endif

/* src/dsso_pkg.sv */
/*
 * Types shared by the drive status output block.
 * Assumes compilation before every module of the block.
 */
`default_nettype none
package dsso_pkg;
    typedef enum logic [1:0] {DRV_STOP, DRV_FWD, DRV_REV} dsso_drive_t;
    typedef struct packed {
        logic fwd;
        logic rev;
    } dsso_cmd_t;
    typedef struct packed {
        logic rtu;
        logic [1:0] src;
        logic [1:0] lcm;
    } dsso_ctrl_t;
    typedef struct packed {
        logic link_loss;
        logic run_cmd;
        logic heat_warn;
        logic low_cur;
        logic ready;
        logic fwd_run;
    } dsso_flags_t;
endpackage
`default_nettype wire

/* src/dsso_pin_sync.sv */
/*
 * Three-stage synchroniser for pin inputs with agreement filter.
 * Assumes asynchronous inputs; the output changes once stages two
 * and three agree.
 */
`timescale 1ns/1ps
`default_nettype none
module dsso_pin_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic [2:0] stage;
        logic [2:0] next_stage;
        logic held;
        logic next_held;
        always_comb begin
            next_stage = {stage[1:0], din[i]};
            next_held = (stage[1] == stage[2]) ? stage[2] : held;
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                stage <= 3'h0;
                held <= 1'b0;
            end else begin
                stage <= next_stage;
                held <= next_held;
            end
        end
        assign dout[i] = held;
    end
endmodule
`default_nettype wire

/* src/dsso_link_timer.sv */
/*
 * Serial reception timeout and link loss flag.
 * Assumes a one-cycle receive strobe on the block clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dsso_link_timer #(
    parameter int TICK_CYCLES = 1000000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    input wire logic rx_strobe,
    input wire logic [15:0] limit,
    // Status
    output logic link_loss,
    output logic timeout_event
);
    localparam int PW = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);
    logic [PW-1:0] pre;
    logic [PW-1:0] next_pre;
    logic [15:0] ticks;
    logic [15:0] next_ticks;
    logic next_loss;
    logic tick;
    logic fire;

    always_comb begin
        tick = (pre == PRE_LAST);
        // A zero limit switches the timeout off
        fire = enable && (limit != 16'h0000) && !link_loss && tick &&
               (ticks == limit - 16'h0001); // [R3]
        next_pre = tick ? '0 : pre + 1'b1;
        next_ticks = (tick && !link_loss) ? ticks + 16'h0001 : ticks;
        // Set wins over a clear arriving in the same cycle
        next_loss = fire | (link_loss & ~rx_strobe); // [R2]
        if (rx_strobe || link_loss) begin
            next_pre = '0;
        end
        if (rx_strobe) begin
            next_ticks = 16'h0000;
        end
        if (!enable || limit == 16'h0000) begin
            next_pre = '0;
            next_ticks = 16'h0000;
            next_loss = 1'b0; // [R1]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre <= '0;
            ticks <= 16'h0000;
            link_loss <= 1'b0;
        end else begin
            pre <= next_pre;
            ticks <= next_ticks;
            link_loss <= next_loss;
        end
    end

    assign timeout_event = fire;
endmodule
`default_nettype wire

/* src/dsso_top.sv */
/*
 * Drive status output block: status flags, drive direction state,
 * register port and the terminal and relay output selectors.
 * Assumes command, measurement and serial inputs other than the
 * terminal pins come from logic on CLK_SYS.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dsso_cfg.svh"
module dsso_top import dsso_pkg::*; #(
    parameter int TICK_CYCLES = `DSSO_TICK_CYCLES,
    parameter logic [15:0] RATED_CURRENT = 16'h0400
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Command terminal pins
    input wire logic FW_PIN,
    input wire logic RV_PIN,
    // Serial receiver
    input wire logic SER_RX_STROBE,
    input wire logic SER_FWD,
    input wire logic SER_REV,
    // Measurements and drive condition
    input wire logic [7:0] HEATSINK_TEMP,
    input wire logic [15:0] OUT_CURRENT,
    input wire logic CONST_SPEED,
    input wire logic POWER_OK,
    input wire logic DRIVE_TRIP,
    // Motor drive
    output logic DRIVE_FWD,
    output logic DRIVE_REV,
    // Status outputs
    output dsso_flags_t STATUS,
    output logic TERM_OUT,
    output logic RELAY_OUT
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [16:0] LOCUR_MAX = 17'({1'b0, RATED_CURRENT} << 1);
    dsso_ctrl_t ctrl;
    dsso_ctrl_t next_ctrl;
    logic [15:0] tmo_limit;
    logic [15:0] next_tmo_limit;
    logic [7:0] heat_level;
    logic [7:0] next_heat_level;
    logic [15:0] locur_level;
    logic [15:0] next_locur_level;
    logic [5:0] term_sel;
    logic [5:0] next_term_sel;
    logic [5:0] relay_sel;
    logic [5:0] next_relay_sel;
    dsso_cmd_t swcmd;
    dsso_cmd_t next_swcmd;
    logic [31:0] next_rdata;
    dsso_drive_t state;
    dsso_drive_t next_state;
    dsso_flags_t flags;
    dsso_flags_t next_flags;
    logic next_term_out;
    logic next_relay_out;
    dsso_cmd_t pin_cmd;
    dsso_cmd_t sel_cmd;
    logic ready_now;
    logic link_loss;
    logic tmo_event;

    // ------------------------------------------------------------
    // Terminal pins and serial timeout
    // ------------------------------------------------------------
    dsso_pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .din({FW_PIN, RV_PIN}),
        .dout(pin_cmd)
    );

    dsso_link_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_link_timer (
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .enable(ctrl.rtu),
        .rx_strobe(SER_RX_STROBE),
        .limit(tmo_limit),
        .link_loss(link_loss),
        .timeout_event(tmo_event)
    );

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_tmo_limit = tmo_limit;
        next_heat_level = heat_level;
        next_locur_level = locur_level;
        next_term_sel = term_sel;
        next_relay_sel = relay_sel;
        next_swcmd = swcmd;
        next_rdata = 32'h0000_0000;
        if (REG_WR) begin
            case (REG_ADDR)
                `DSSO_OFF_CTRL: begin
                    next_ctrl.rtu = REG_WDATA[`DSSO_CTRL_RTU];
                    next_ctrl.src = REG_WDATA[`DSSO_CTRL_SRC_LSB +: 2];
                    next_ctrl.lcm = REG_WDATA[`DSSO_CTRL_LCM_LSB +: 2];
                end
                `DSSO_OFF_TMO: begin
                    // Limit saturates at 99.99 s
                    next_tmo_limit = (REG_WDATA[15:0] > `DSSO_TMO_MAX) ?
                        `DSSO_TMO_MAX : REG_WDATA[15:0]; // [R3]
                end
                `DSSO_OFF_HEAT: begin
                    next_heat_level = (REG_WDATA[7:0] > `DSSO_HEAT_MAX) ?
                        `DSSO_HEAT_MAX : REG_WDATA[7:0]; // [R7]
                end
                `DSSO_OFF_LOCUR: begin
                    next_locur_level =
                        ({1'b0, REG_WDATA[15:0]} > LOCUR_MAX) ?
                        LOCUR_MAX[15:0] : REG_WDATA[15:0]; // [R9]
                end
                `DSSO_OFF_SEL: begin
                    next_term_sel = REG_WDATA[`DSSO_SEL_TERM_LSB +: 6];
                    next_relay_sel = REG_WDATA[`DSSO_SEL_RELAY_LSB +: 6];
                end
                `DSSO_OFF_SWCMD: begin
                    next_swcmd.fwd = REG_WDATA[`DSSO_SWCMD_FWD];
                    next_swcmd.rev = REG_WDATA[`DSSO_SWCMD_REV];
                end
                default: begin
                end
            endcase
        end
        if (REG_RD) begin
            case (REG_ADDR)
                `DSSO_OFF_CTRL: next_rdata = {27'h000_0000, ctrl.lcm,
                                              ctrl.src, ctrl.rtu};
                `DSSO_OFF_TMO: next_rdata = {16'h0000, tmo_limit};
                `DSSO_OFF_HEAT: next_rdata = {24'h00_0000, heat_level};
                `DSSO_OFF_LOCUR: next_rdata = {16'h0000, locur_level};
                `DSSO_OFF_SEL: next_rdata = {18'h0_0000, relay_sel,
                                             2'h0, term_sel};
                `DSSO_OFF_SWCMD: next_rdata = {30'h0000_0000, swcmd.rev,
                                               swcmd.fwd};
                `DSSO_OFF_STAT: next_rdata = {22'h00_0000, state,
                                              2'h0, flags};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ctrl <= `DSSO_CTRL_RST;
            tmo_limit <= `DSSO_TMO_RST;
            heat_level <= `DSSO_HEAT_RST;
            locur_level <= `DSSO_LOCUR_RST;
            term_sel <= `DSSO_SEL_RST;
            relay_sel <= `DSSO_SEL_RST;
            swcmd <= 2'h0;
            REG_RDATA <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            tmo_limit <= next_tmo_limit;
            heat_level <= next_heat_level;
            locur_level <= next_locur_level;
            term_sel <= next_term_sel;
            relay_sel <= next_relay_sel;
            swcmd <= next_swcmd;
            REG_RDATA <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Output selector
    // ------------------------------------------------------------
    // Terminal and relay share most codes but differ for a few
    function automatic logic pick(input logic [5:0] code,
                                  input logic relay,
                                  input dsso_flags_t f);
        logic hit;
        hit = 1'b0;
        case (code)
            `DSSO_TSEL_LINK: hit = !relay && f.link_loss;
            `DSSO_RSEL_LINK: hit = relay && f.link_loss;
            `DSSO_TSEL_RUNCMD: hit = !relay && f.run_cmd;
            `DSSO_RSEL_RUNCMD: hit = relay && f.run_cmd;
            `DSSO_SEL_HEAT: hit = f.heat_warn; // [R8]
            `DSSO_SEL_LOCUR: hit = f.low_cur; // [R12]
            `DSSO_SEL_READY: hit = f.ready; // [R15]
            `DSSO_SEL_FWDRUN: hit = f.fwd_run; // [R17]
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Drive state, flags and outputs
    // ------------------------------------------------------------
    always_comb begin
        ready_now = POWER_OK && !DRIVE_TRIP; // [R13]
        case (ctrl.src) // [R5]
            `DSSO_SRC_SERIAL: sel_cmd = {SER_FWD, SER_REV};
            `DSSO_SRC_SW: sel_cmd = swcmd;
            default: sel_cmd = pin_cmd;
        endcase
        // Commands are ignored, and the motor held stopped, while not ready
        if (!ready_now) begin
            next_state = DRV_STOP; // [R14]
        end else if (sel_cmd.fwd && sel_cmd.rev) begin
            next_state = DRV_STOP; // [R6]
        end else if (sel_cmd.fwd) begin
            next_state = DRV_FWD;
        end else if (sel_cmd.rev) begin
            next_state = DRV_REV;
        end else begin
            next_state = DRV_STOP;
        end
        next_flags.link_loss = link_loss; // [R1]
        next_flags.run_cmd = sel_cmd.fwd || sel_cmd.rev; // [R4]
        next_flags.heat_warn = HEATSINK_TEMP > heat_level; // [R7]
        // Unlisted mode codes act like mode 00
        next_flags.low_cur = (state != DRV_STOP) &&
            (OUT_CURRENT <= locur_level) && // [R9]
            ((ctrl.lcm != `DSSO_LCM_CONST) || CONST_SPEED); // [R10] [R11]
        next_flags.ready = ready_now; // [R13]
        next_flags.fwd_run = (state == DRV_FWD); // [R16]
        next_term_out = pick(term_sel, 1'b0, flags); // [R19] [R20]
        next_relay_out = pick(relay_sel, 1'b1, flags); // [R19] [R20]
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            state <= DRV_STOP;
            flags <= 6'h00;
            TERM_OUT <= 1'b0;
            RELAY_OUT <= 1'b0;
        end else begin
            state <= next_state;
            flags <= next_flags;
            TERM_OUT <= next_term_out;
            RELAY_OUT <= next_relay_out;
        end
    end

    assign DRIVE_FWD = (state == DRV_FWD);
    assign DRIVE_REV = (state == DRV_REV);
    assign STATUS = flags;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);

    a_loss_needs_rtu: assert property ( // [R1]
        !ctrl.rtu |=> ##1 !flags.link_loss)
        else $error("link loss shown without RTU mode");
    a_loss_holds: assert property ( // [R2]
        link_loss && !SER_RX_STROBE && ctrl.rtu && tmo_limit != 16'h0000
        |=> link_loss)
        else $error("link loss dropped without received data");
    a_loss_release: assert property ( // [R2]
        link_loss && SER_RX_STROBE && !tmo_event |=> !link_loss ##1
        !flags.link_loss)
        else $error("link loss not released by received data");
    a_timeout_sets: assert property ( // [R3]
        tmo_event |=> link_loss ##1 flags.link_loss)
        else $error("timeout did not raise link loss");
    a_run_cmd_follow: assert property ( // [R4]
        flags.run_cmd == $past(sel_cmd.fwd || sel_cmd.rev))
        else $error("run command flag does not follow command");
    a_serial_source: assert property ( // [R5]
        ctrl.src == `DSSO_SRC_SERIAL && SER_FWD && !SER_REV && ready_now
        |=> state == DRV_FWD && DRIVE_FWD && flags.run_cmd)
        else $error("serial command source not followed");
    a_both_stop: assert property ( // [R6]
        ready_now && sel_cmd.fwd && sel_cmd.rev |=> state == DRV_STOP)
        else $error("both commands did not stop the motor");
    a_heat_compare: assert property ( // [R7]
        $past(RESETN) |-> flags.heat_warn == $past(HEATSINK_TEMP > heat_level))
        else $error("heat sink warning wrong");
    a_term_heat: assert property ( // [R8]
        term_sel == `DSSO_SEL_HEAT && $stable(term_sel)
        |-> TERM_OUT == $past(flags.heat_warn))
        else $error("terminal does not route heat warning");
    a_locur_cause: assert property ( // [R9]
        flags.low_cur |-> $past(state != DRV_STOP &&
                                OUT_CURRENT <= locur_level))
        else $error("low current flag without cause");
    a_locur_run: assert property ( // [R10]
        ctrl.lcm == `DSSO_LCM_RUN && state != DRV_STOP &&
        OUT_CURRENT <= locur_level |=> flags.low_cur)
        else $error("low current missed in mode 00");
    a_locur_const: assert property ( // [R11]
        ctrl.lcm == `DSSO_LCM_CONST && !CONST_SPEED |=> !flags.low_cur)
        else $error("low current outside constant speed");
    a_relay_locur: assert property ( // [R12]
        relay_sel == `DSSO_SEL_LOCUR && $stable(relay_sel)
        |-> RELAY_OUT == $past(flags.low_cur))
        else $error("relay does not route low current");
    a_ready_follow: assert property ( // [R13]
        $past(RESETN) |-> flags.ready == $past(POWER_OK && !DRIVE_TRIP))
        else $error("ready flag wrong");
    a_not_ready_stop: assert property ( // [R14]
        !ready_now |=> state == DRV_STOP ##1 !flags.fwd_run)
        else $error("command acted on while not ready");
    a_relay_ready: assert property ( // [R15]
        relay_sel == `DSSO_SEL_READY && $stable(relay_sel)
        |-> RELAY_OUT == $past(flags.ready))
        else $error("relay does not route ready");
    a_fwd_flag: assert property ( // [R16]
        flags.fwd_run == $past(state == DRV_FWD))
        else $error("forward running flag wrong");
    a_relay_fwd: assert property ( // [R17]
        relay_sel == `DSSO_SEL_FWDRUN && $stable(relay_sel)
        |-> RELAY_OUT == $past(flags.fwd_run))
        else $error("relay does not route forward running");
    a_unused_code: assert property ( // [R19] [R20]
        term_sel == 6'h00 |=> !TERM_OUT)
        else $error("terminal high on unused code");

    c_link_loss: cover property (tmo_event ##1 link_loss ##[1:50]
                                 !link_loss);
    c_fwd_to_rev: cover property (state == DRV_FWD ##[1:20]
                                  state == DRV_REV);
    c_low_cur: cover property (ctrl.lcm == `DSSO_LCM_CONST &&
                               flags.low_cur);
    c_term_heat: cover property (TERM_OUT && term_sel == `DSSO_SEL_HEAT);
endmodule
`default_nettype wire

/* verification/dsso_ctl_model.sv */
/*
 * Controller model driving the forward and reverse command pins.
 * Assumes ready is the block's ready flag on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dsso_ctl_model (
    // Clock and ready
    input wire logic clk,
    input wire logic ready,
    // Wanted commands and pins
    input wire logic want_fwd,
    input wire logic want_rev,
    output logic fw_pin,
    output logic rv_pin
);
    initial {fw_pin, rv_pin} = 2'b00;
    // Commands only go out while ready is shown
    always @(posedge clk) begin
        fw_pin <= want_fwd & ready;
        rv_pin <= want_rev & ready;
    end
endmodule
`default_nettype wire

/* verification/tb.sv */
/*
 * Self-checking bench of the drive status output block.
 * Assumes dsso_top, dsso_pkg and the controller model are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dsso_cfg.svh"
module tb import dsso_pkg::*; ();
    logic clk = 0, rst_n = 0, wr, rd, stb, sfw, srv, cs, pok, trip;
    logic wf, wv, fwp, rvp, dfw, drv, tout, rout;
    logic [7:0] addr, temp;
    logic [15:0] cur;
    logic [31:0] wd, rdat, r;
    dsso_flags_t st;
    int mismatches = 0, comparisons = 0, seed = 32'h6a4a, i;
    dsso_top #(.TICK_CYCLES(10)) i_dut (.CLK_SYS(clk), .RESETN(rst_n),
        .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdat), .FW_PIN(fwp), .RV_PIN(rvp), .SER_RX_STROBE(stb),
        .SER_FWD(sfw), .SER_REV(srv), .HEATSINK_TEMP(temp),
        .OUT_CURRENT(cur), .CONST_SPEED(cs), .POWER_OK(pok),
        .DRIVE_TRIP(trip), .DRIVE_FWD(dfw), .DRIVE_REV(drv), .STATUS(st),
        .TERM_OUT(tout), .RELAY_OUT(rout));
    dsso_ctl_model i_ctl (.clk(clk), .ready(st.ready), .want_fwd(wf),
        .want_rev(wv), .fw_pin(fwp), .rv_pin(rvp));
    initial forever #5 clk = ~clk;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic give_verdict;
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdat, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic f_heat(input logic [7:0] t);
        return t > `DSSO_HEAT_MAX;
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {wr, rd, stb, sfw, srv, cs, trip, wf, wv} = '0;
        pok = 1;
        addr = 0;
        wd = 0;
        temp = 0;
        cur = 16'hffff;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rreg(`DSSO_OFF_HEAT, 32'h0000_005a);
        rreg(8'h20, 32'h0000_0000);
        wreg(`DSSO_OFF_HEAT, 32'h0000_00ff);
        rreg(`DSSO_OFF_HEAT, 32'h0000_006e);
        wreg(`DSSO_OFF_SEL, 32'h0000_2a2a);
        // Boundary temperatures first, then random ones
        for (i = 0; i < 10; i++) begin
            r = $random(seed);
            @(posedge clk) temp <= (i < 2) ? 8'h6e + i[7:0] : r[7:0];
            settle(4);
            chk(st.heat_warn, f_heat(temp));
            chk({tout, rout}, {2{f_heat(temp)}});
        end
        @(posedge clk) temp <= 8'h00;
        // Level saturates at twice the default rated current
        wreg(`DSSO_OFF_LOCUR, 32'h0000_ffff);
        rreg(`DSSO_OFF_LOCUR, 32'h0000_0800);
        wreg(`DSSO_OFF_LOCUR, 32'h0000_0100);
        wreg(`DSSO_OFF_SEL, 32'h0000_2b2b);
        wreg(`DSSO_OFF_CTRL, 32'h0000_0002);
        sfw <= 1'b1;
        cur <= 16'h0100;
        settle(5);
        chk({st.run_cmd, st.fwd_run}, 2'b11);
        chk(st.low_cur, 1'b1);
        chk({tout, rout, dfw, drv}, 4'b1110);
        @(posedge clk) cur <= 16'h0101;
        settle(4);
        chk(st.low_cur, 1'b0);
        @(posedge clk) cur <= 16'h0100;
        // Speed source is not the terminal here, so mode 01 is safe
        wreg(`DSSO_OFF_CTRL, 32'h0000_000a);
        settle(4);
        chk(st.low_cur, 1'b0);
        @(posedge clk) cs <= 1'b1;
        settle(4);
        chk(st.low_cur, 1'b1);
        wreg(`DSSO_OFF_SEL, 32'h0000_3300);
        settle(4);
        chk({tout, rout}, 2'b01);
        @(posedge clk) srv <= 1'b1;
        settle(5);
        chk({st.run_cmd, dfw, drv, rout}, 4'b1000);
        @(posedge clk) sfw <= 1'b0;
        settle(5);
        chk({st.fwd_run, drv}, 2'b01);
        wreg(`DSSO_OFF_SEL, 32'h0000_3200);
        pok <= 1'b0;
        settle(5);
        chk({st.ready, rout, drv}, 3'b000);
        @(posedge clk);
        pok <= 1'b1;
        srv <= 1'b0;
        wreg(`DSSO_OFF_CTRL, 32'h0000_0000);
        wf <= 1'b1;
        settle(10);
        chk({rout, dfw}, 2'b11);
        @(posedge clk) wv <= 1'b1;
        settle(10);
        chk({dfw, drv}, 2'b00);
        @(posedge clk) {wf, wv} <= 2'b00;
        // Software command source, run command codes on both outputs
        wreg(`DSSO_OFF_SEL, 32'h0000_292c);
        wreg(`DSSO_OFF_SWCMD, 32'h0000_0001);
        wreg(`DSSO_OFF_CTRL, 32'h0000_0004);
        settle(5);
        chk({tout, rout, dfw}, 3'b111);
        rreg(`DSSO_OFF_STAT, 32'h0000_0117);
        wreg(`DSSO_OFF_TMO, 32'h0000_ffff);
        rreg(`DSSO_OFF_TMO, 32'h0000_270f);
        wreg(`DSSO_OFF_TMO, 32'h0000_0002);
        wreg(`DSSO_OFF_SEL, 32'h0000_3420);
        wreg(`DSSO_OFF_CTRL, 32'h0000_0001);
        settle(10);
        chk(st.link_loss, 1'b0);
        for (i = 0; i < 60 && st.link_loss !== 1'b1; i++) settle(1);
        if (i == 60) begin
            mismatches++;
            give_verdict();
        end
        settle(2);
        chk({tout, rout}, 2'b11);
        @(posedge clk) stb <= 1'b1;
        @(posedge clk) stb <= 1'b0;
        settle(3);
        chk(st.link_loss, 1'b0);
        wreg(`DSSO_OFF_CTRL, 32'h0000_0000);
        settle(40);
        chk({st.link_loss, tout}, 2'b00);
        give_verdict();
    end
endmodule
`default_nettype wire
